// ---- src/coder_pkg.sv ----
// Overview of operation
// - Select 01 turns on Manchester coding both ways, only in packet mode.
// - NRZ one goes out as chips 10, zero as 01; receive maps back alike.
// - With Manchester on, user bit rate is half the chip rate.
// - Only payload and CRC are coded; preamble and sync stay plain NRZ.
// - Chip rate is constant over the packet and set by the divider.
// - Byte side always carries plain NRZ bytes; coding stays inside the path.
// - Select 10 whitens transmit data and de-whitens received data, only in packet mode.
// - Whitening XORs payload and 2-byte CRC with a 9-bit LFSR sequence.
// - Receive XORs with the same LFSR sequence to recover plain bytes.
// - Whitening keeps one chip per bit, so bit rate equals chip rate.
// - Data path mode: 00 packet, 01 reserved, 10 and 11 continuous.
// - Divider is 16 bits; upper byte resets to 0x1A.
// - Lower byte resets to 0x0B; rate is crystal over the divider.
// - Transmit appends a two-byte CRC computed over the payload.
package coder_pkg;
    localparam int          DIV_W            = 16;
    localparam logic [6:0]  ADDR_DATA_MODUL  = 7'h02;
    localparam logic [6:0]  ADDR_DIV_HIGH    = 7'h03;
    localparam logic [6:0]  ADDR_DIV_LOW     = 7'h04;
    localparam logic [7:0]  RST_DATA_MODUL   = 8'h00;
    localparam logic [7:0]  RST_DIV_HIGH     = 8'h1A;
    localparam logic [7:0]  RST_DIV_LOW      = 8'h0B;
    localparam int          MODE_LSB         = 5;
    localparam int          MODTYPE_LSB      = 3;
    localparam int          SHAPING_LSB      = 0;
    localparam logic [1:0]  DM_PACKET        = 2'h0;
    localparam logic [1:0]  DM_RESERVED      = 2'h1;
    localparam logic [1:0]  DM_CONT_SYNC     = 2'h2;
    localparam logic [1:0]  DM_CONT_RAW      = 2'h3;
    localparam logic [1:0]  LC_NONE          = 2'h0;
    localparam logic [1:0]  LC_MANCHESTER    = 2'h1;
    localparam logic [1:0]  LC_WHITEN        = 2'h2;
    localparam int          LFSR_W           = 9;
    localparam logic [8:0]  LFSR_SEED        = 9'h1FF;
    localparam int          LFSR_TAP         = 5;
    localparam logic [15:0] CRC_POLY         = 16'h1021;
    localparam logic [15:0] CRC_SEED         = 16'h1D0F;
    localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
    localparam logic [1:0]  CRC_BYTES        = 2'h2;
    localparam logic [2:0]  LAST_BIT_IDX     = 3'h7;
    localparam logic [7:0]  READ_NONE        = 8'h00;
    typedef enum logic [1:0] {TX_HDR, TX_BODY, TX_CRC} tx_kind_e;
endpackage

// ---- src/coder_if.sv ----
`timescale 1ns/1ps
interface rate_if;
    logic                     ce;
    logic [coder_pkg::DIV_W-1:0] divider;
    logic                     tick;
    modport ctrl (output ce, output divider, input tick);
    modport gen  (input ce, input divider, output tick);
endinterface // rate_if

interface lfsr_if;
    logic ce;
    logic restart;
    logic step;
    logic bit_out;
    modport ctrl (output ce, output restart, output step, input bit_out);
    modport gen  (input ce, input restart, input step, output bit_out);
endinterface // lfsr_if

// ---- src/rate_tick_gen.sv ----
`timescale 1ns/1ps
module rate_tick_gen
    import coder_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    rate_if.gen      rif
);
    logic [DIV_W-1:0] cnt_r;
    logic             tick_r;
    wire  logic       wrap = (cnt_r == '0);

    // Divider of 0 or 1 gives a tick every clock rather than stalling
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else if (rif.ce) begin
            tick_r <= wrap;
            cnt_r  <= wrap ? ((rif.divider == '0) ? '0 : rif.divider - 1'b1)
                           : cnt_r - 1'b1;
        end
    end

    assign rif.tick = tick_r & rif.ce;
endmodule // rate_tick_gen

// ---- src/whiten_lfsr.sv ----
`timescale 1ns/1ps
module whiten_lfsr
    import coder_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    lfsr_if.gen      lif
);
    logic [LFSR_W-1:0] st_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= LFSR_SEED;
        end else if (lif.ce && lif.restart) begin
            st_r <= LFSR_SEED;
        end else if (lif.ce && lif.step) begin
            st_r <= {st_r[0] ^ st_r[LFSR_TAP], st_r[LFSR_W-1:1]};
        end
    end

    assign lif.bit_out = st_r[0];
endmodule // whiten_lfsr

// ---- src/dc_free_line_coder.sv ----
`timescale 1ns/1ps
module dc_free_line_coder
    import coder_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic [6:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    input  wire logic [1:0] line_coding_select,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_valid,
    input  wire logic       tx_header,
    input  wire logic       tx_last,
    output logic            tx_ready,
    output logic            tx_chip,
    output logic            tx_chip_stb,
    output logic            tx_active,
    input  wire logic       rx_chip,
    input  wire logic       rx_chip_stb,
    input  wire logic       rx_sync_found,
    input  wire logic       rx_stop,
    output logic      [7:0] rx_byte,
    output logic            rx_byte_stb,
    output logic            rx_code_err,
    output logic            rx_active
);
    logic [1:0]  mode_r;
    logic [1:0]  modtype_r;
    logic [1:0]  shaping_r;
    logic [7:0]  div_hi_r;
    logic [7:0]  div_lo_r;
    logic [7:0]  rdata_r;
    logic        rvalid_r;

    // Register port decode
    wire logic       wr_modul  = reg_wr & (reg_addr == ADDR_DATA_MODUL);
    wire logic       wr_div_hi = reg_wr & (reg_addr == ADDR_DIV_HIGH);
    wire logic       wr_div_lo = reg_wr & (reg_addr == ADDR_DIV_LOW);
    wire logic [7:0] modul_rd  = {1'b0, mode_r, modtype_r, 1'b0, shaping_r};
    wire logic [7:0] rd_mux    = (reg_addr == ADDR_DATA_MODUL) ? modul_rd :
                                 (reg_addr == ADDR_DIV_HIGH)   ? div_hi_r :
                                 (reg_addr == ADDR_DIV_LOW)    ? div_lo_r :
                                                                 READ_NONE;

    // Coding is a packet handler feature, so continuous modes bypass it
    wire logic pkt_mode = (mode_r == DM_PACKET);
    wire logic man_on   = pkt_mode & (line_coding_select == LC_MANCHESTER);
    // Select 11 enables neither scheme; only one may run at a time
    wire logic wht_on   = pkt_mode & (line_coding_select == LC_WHITEN);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r    <= RST_DATA_MODUL[MODE_LSB+:2];
            modtype_r <= RST_DATA_MODUL[MODTYPE_LSB+:2];
            shaping_r <= RST_DATA_MODUL[SHAPING_LSB+:2];
            div_hi_r  <= RST_DIV_HIGH;
            div_lo_r  <= RST_DIV_LOW;
            rdata_r   <= READ_NONE;
            rvalid_r  <= 1'b0;
        end else if (ce) begin
            if (wr_modul) begin
                mode_r    <= reg_wdata[MODE_LSB+:2];
                modtype_r <= reg_wdata[MODTYPE_LSB+:2];
                shaping_r <= reg_wdata[SHAPING_LSB+:2];
            end
            if (wr_div_hi) div_hi_r <= reg_wdata;
            if (wr_div_lo) div_lo_r <= reg_wdata;
            rdata_r  <= reg_rd ? rd_mux : rdata_r;
            rvalid_r <= reg_rd;
        end
    end

    rate_if rif ();
    lfsr_if tx_lf ();
    lfsr_if rx_lf ();

    // One chip per tick from preamble to CRC; rate is clk over the divider
    assign rif.ce      = ce;
    assign rif.divider = {div_hi_r, div_lo_r};

    rate_tick_gen u_rate (
        .clk (clk),
        .rst (rst),
        .rif (rif.gen)
    );

    whiten_lfsr u_tx_lfsr (
        .clk (clk),
        .rst (rst),
        .lif (tx_lf.gen)
    );

    whiten_lfsr u_rx_lfsr (
        .clk (clk),
        .rst (rst),
        .lif (rx_lf.gen)
    );

    // Transmit path
    tx_kind_e    tx_kind_r;
    tx_kind_e    tx_kind_nxt;
    logic [7:0]  tx_sh_r;
    logic [7:0]  tx_sh_nxt;
    logic [3:0]  tx_bits_r;
    logic [3:0]  tx_bits_nxt;
    logic        tx_half_r;
    logic        tx_half_nxt;
    logic [1:0]  crc_left_r;
    logic [1:0]  crc_left_nxt;
    logic [15:0] crc_r;
    logic        tx_ready_r;
    logic        tx_chip_r;
    logic        tx_stb_r;
    logic        tx_act_r;

    wire logic        tick      = rif.tick;
    wire logic        tx_coded  = (tx_kind_r != TX_HDR);
    wire logic        tx_busy   = (tx_bits_r != 4'h0);
    wire logic        tx_two    = tx_coded & man_on;
    wire logic        tx_dbit   = tx_sh_r[7]
                                  ^ (tx_coded & wht_on & tx_lf.bit_out);
    // First chip is the bit, second its inverse: 1 -> 10, 0 -> 01
    wire logic        tx_chipv  = tx_half_r ? ~tx_dbit : tx_dbit;
    wire logic        tx_bitend = tick & tx_busy & (~tx_two | tx_half_r);
    wire logic        load_user = tx_valid & tx_ready_r;
    wire logic        load_crc  = ~tx_busy & (crc_left_r != 2'h0);
    wire logic        first_pl  = load_user & ~tx_header
                                  & (tx_kind_r != TX_BODY);
    wire logic [15:0] crc_out   = ~crc_r;
    wire logic        crc_fb    = crc_r[15] ^ tx_sh_r[7];
    wire logic [15:0] crc_step  = {crc_r[14:0], 1'b0}
                                  ^ (crc_fb ? CRC_POLY : 16'h0000);

    assign tx_lf.ce      = ce;
    assign tx_lf.restart = first_pl;
    assign tx_lf.step    = tx_bitend & tx_coded;

    always_comb begin
        tx_kind_nxt  = tx_kind_r;
        tx_sh_nxt    = tx_sh_r;
        tx_bits_nxt  = tx_bits_r;
        tx_half_nxt  = tx_half_r;
        crc_left_nxt = crc_left_r;
        if (load_user) begin
            tx_sh_nxt    = tx_byte;
            tx_bits_nxt  = BITS_PER_BYTE;
            tx_half_nxt  = 1'b0;
            tx_kind_nxt  = tx_header ? TX_HDR : TX_BODY;
            crc_left_nxt = (~tx_header & tx_last) ? CRC_BYTES : 2'h0;
        end else if (load_crc) begin
            tx_sh_nxt    = (crc_left_r == CRC_BYTES) ? crc_out[15:8]
                                                     : crc_out[7:0];
            tx_bits_nxt  = BITS_PER_BYTE;
            tx_half_nxt  = 1'b0;
            tx_kind_nxt  = TX_CRC;
            crc_left_nxt = crc_left_r - 2'h1;
        end else if (tick && tx_busy) begin
            if (tx_two && !tx_half_r) begin
                tx_half_nxt = 1'b1;
            end else begin
                tx_half_nxt = 1'b0;
                tx_sh_nxt   = {tx_sh_r[6:0], 1'b0};
                tx_bits_nxt = tx_bits_r - 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_kind_r  <= TX_HDR;
            tx_sh_r    <= 8'h00;
            tx_bits_r  <= 4'h0;
            tx_half_r  <= 1'b0;
            crc_left_r <= 2'h0;
            tx_ready_r <= 1'b0;
            tx_chip_r  <= 1'b0;
            tx_stb_r   <= 1'b0;
            tx_act_r   <= 1'b0;
        end else if (ce) begin
            tx_kind_r  <= tx_kind_nxt;
            tx_sh_r    <= tx_sh_nxt;
            tx_bits_r  <= tx_bits_nxt;
            tx_half_r  <= tx_half_nxt;
            crc_left_r <= crc_left_nxt;
            tx_ready_r <= (tx_bits_nxt == 4'h0) && (crc_left_nxt == 2'h0);
            tx_stb_r   <= tick & tx_busy;
            tx_chip_r  <= (tick & tx_busy) ? tx_chipv : tx_chip_r;
            tx_act_r   <= (tx_bits_nxt != 4'h0) || (crc_left_nxt != 2'h0);
        end
    end

    // CRC runs over the plain payload bits, before whitening
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            crc_r <= CRC_SEED;
        end else if (ce) begin
            if (first_pl) begin
                crc_r <= CRC_SEED;
            end else if (tx_bitend && tx_kind_r == TX_BODY) begin
                crc_r <= crc_step;
            end
        end
    end

    // Receive path; chips come strobed from the demodulator
    logic       rx_on_r;
    logic       rx_half_r;
    logic       rx_first_r;
    logic [7:0] rx_sh_r;
    logic [2:0] rx_cnt_r;
    logic [7:0] rx_byte_r;
    logic       rx_bstb_r;
    logic       rx_err_r;

    wire logic       rx_take  = rx_on_r & rx_chip_stb;
    wire logic       rx_hold  = rx_take & man_on & ~rx_half_r;
    wire logic       rx_bitok = rx_take & ~rx_hold;
    // A pair's first chip is the data bit: 10 -> 1, 01 -> 0
    wire logic       rx_raw   = man_on ? rx_first_r : rx_chip;
    wire logic       rx_bit   = rx_raw ^ (wht_on & rx_lf.bit_out);
    // 00 and 11 are not legal pairs; the first chip is still taken
    wire logic       rx_bad   = rx_bitok & man_on & (rx_chip == rx_first_r);
    wire logic [7:0] rx_shn   = {rx_sh_r[6:0], rx_bit};

    assign rx_lf.ce      = ce;
    assign rx_lf.restart = rx_sync_found;
    assign rx_lf.step    = rx_bitok;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_on_r    <= 1'b0;
            rx_half_r  <= 1'b0;
            rx_first_r <= 1'b0;
            rx_sh_r    <= 8'h00;
            rx_cnt_r   <= 3'h0;
            rx_byte_r  <= 8'h00;
            rx_bstb_r  <= 1'b0;
            rx_err_r   <= 1'b0;
        end else if (ce) begin
            rx_bstb_r <= 1'b0;
            rx_err_r  <= rx_bad;
            if (rx_sync_found) begin
                rx_on_r   <= 1'b1;
                rx_half_r <= 1'b0;
                rx_cnt_r  <= 3'h0;
            end else if (rx_stop) begin
                rx_on_r <= 1'b0;
            end else if (rx_hold) begin
                rx_first_r <= rx_chip;
                rx_half_r  <= 1'b1;
            end else if (rx_bitok) begin
                rx_half_r <= 1'b0;
                rx_sh_r   <= rx_shn;
                rx_cnt_r  <= rx_cnt_r + 3'h1;
                if (rx_cnt_r == LAST_BIT_IDX) begin
                    rx_byte_r <= rx_shn;
                    rx_bstb_r <= 1'b1;
                end
            end
        end
    end

    assign reg_rdata   = rdata_r;
    assign reg_rvalid  = rvalid_r;
    assign tx_ready    = tx_ready_r;
    assign tx_chip     = tx_chip_r;
    assign tx_chip_stb = tx_stb_r;
    assign tx_active   = tx_act_r;
    assign rx_byte     = rx_byte_r;
    assign rx_byte_stb = rx_bstb_r;
    assign rx_code_err = rx_err_r;
    assign rx_active   = rx_on_r;
endmodule // dc_free_line_coder

// ---- tb/coder_properties.sv ----
`timescale 1ns/1ps
module coder_properties
    import coder_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ce,
    input wire logic       reg_rd,
    input wire logic       reg_rvalid,
    input wire logic [1:0] line_coding_select,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       tx_chip,
    input wire logic       tx_chip_stb,
    input wire logic       tx_active,
    input wire logic       rx_sync_found,
    input wire logic       rx_stop,
    input wire logic       rx_byte_stb,
    input wire logic       rx_code_err,
    input wire logic       rx_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rd_answer; ce && reg_rd |=> reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    property p_rvalid_cause; reg_rvalid |-> $past(ce && reg_rd); endproperty
    a_rvalid_cause: assert property (p_rvalid_cause)
        else $error("read answer without request");
    property p_chip_hold; !tx_chip_stb |-> $stable(tx_chip); endproperty
    a_chip_hold: assert property (p_chip_hold)
        else $error("chip moved between strobes");
    property p_take; ce && tx_valid && tx_ready |=> (!tx_ready)[*4];
    endproperty
    a_take: assert property (p_take)
        else $error("ready back too soon after take");
    // Ready rises with the last strobe, so look at the cycle before it
    property p_stb_busy; tx_chip_stb |-> !$past(tx_ready); endproperty
    a_stb_busy: assert property (p_stb_busy)
        else $error("chip strobe while ready");
    property p_ready_idle; tx_ready |-> !tx_active; endproperty
    a_ready_idle: assert property (p_ready_idle)
        else $error("ready while active");
    property p_sync; ce && rx_sync_found |=> rx_active; endproperty
    a_sync: assert property (p_sync)
        else $error("sync did not start reception");
    property p_stop; ce && rx_stop && !rx_sync_found |=> !rx_active;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not end reception");
    property p_byte_in_pkt; rx_byte_stb |-> $past(rx_active); endproperty
    a_byte_in_pkt: assert property (p_byte_in_pkt)
        else $error("byte outside packet");
    property p_err_manch;
        rx_code_err |-> $past(line_coding_select) == LC_MANCHESTER;
    endproperty
    a_err_manch: assert property (p_err_manch)
        else $error("code error outside Manchester");
    c_err: cover property (rx_code_err);
    c_whiten: cover property (tx_chip_stb && line_coding_select == LC_WHITEN);
    c_rx: cover property (rx_byte_stb && line_coding_select == LC_MANCHESTER);
endmodule // coder_properties

// ---- tb/line_partner.sv ----
`timescale 1ns/1ps
module line_partner (
    input  wire logic clk,
    input  wire logic tx_chip,
    input  wire logic tx_chip_stb,
    output logic      rx_chip,
    output logic      rx_chip_stb
);
    logic cap[$];
    int   stamp[$];
    int   cnt = 0;
    initial begin
        rx_chip = 1'b0;
        rx_chip_stb = 1'b0;
    end
    always @(posedge clk) begin
        cnt <= cnt + 1;
        if (tx_chip_stb === 1'b1) begin
            cap.push_back(tx_chip);
            stamp.push_back(cnt);
        end
    end
    task automatic play(input logic c[$]);
        foreach (c[i]) begin
            @(posedge clk);
            rx_chip <= c[i];
            rx_chip_stb <= 1'b1;
            @(posedge clk);
            rx_chip_stb <= 1'b0;
            // Not held after the strobe, so a stale level cannot pass
            rx_chip <= ~c[i];
        end
    endtask
endmodule // line_partner

// ---- tb/tb_dc_free_line_coder.sv ----
`timescale 1ns/1ps
module tb_dc_free_line_coder;
    import coder_pkg::*;
    logic clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, reg_rvalid;
    logic [6:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, tx_byte = 0, rx_byte, got;
    logic [1:0] line_coding_select = 0;
    logic tx_valid = 0, tx_header = 0, tx_last = 0, tx_ready, tx_chip;
    logic tx_chip_stb, tx_active, rx_chip, rx_chip_stb, rx_byte_stb;
    logic rx_sync_found = 0, rx_stop = 0, rx_code_err, rx_active;
    int n_errors = 0, n_checks = 0, n_got = 0, n_cerr = 0;
    logic [8:0] lf;
    logic [15:0] crc;
    logic q[$];
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (rx_code_err === 1'b1) n_cerr <= n_cerr + 1;
        if (rx_byte_stb === 1'b1) begin
            got <= rx_byte;
            n_got <= n_got + 1;
        end
    end
    dc_free_line_coder dc_free_line_coder_inst (.clk, .rst, .ce, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
        .line_coding_select, .tx_byte, .tx_valid, .tx_header, .tx_last,
        .tx_ready, .tx_chip, .tx_chip_stb, .tx_active, .rx_chip, .rx_chip_stb,
        .rx_sync_found, .rx_stop, .rx_byte, .rx_byte_stb, .rx_code_err,
        .rx_active);
    line_partner line_partner_inst (.clk, .tx_chip, .tx_chip_stb, .rx_chip,
        .rx_chip_stb);
    task automatic close_out();
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic hang();
        n_errors++;
        close_out();
    endtask
    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [6:0] a, logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [6:0] a, logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", reg_rdata, e);
    endtask
    task automatic wait_ready();
        int i = 0;
        do begin
            @(posedge clk);
            i++;
        // Counter may still run down the reset divider before the first chip
        end while (i < 8000 && tx_ready !== 1'b1);
        if (i == 8000) hang();
    endtask
    task automatic send(logic [7:0] b, logic h, logic l);
        wait_ready();
        tx_byte <= b;
        tx_header <= h;
        tx_last <= l;
        tx_valid <= 1'b1;
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask
    function automatic void put(logic [7:0] b, int m);
        for (int i = 7; i >= 0; i--) begin
            q.push_back(b[i] ^ (m == 2 && lf[0]));
            if (m == 1) q.push_back(~b[i]);
            if (m == 2) lf = {lf[0] ^ lf[LFSR_TAP], lf[8:1]};
        end
    endfunction
    function automatic void crc_in(logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i]) ? CRC_POLY : 16'h0000);
    endfunction
    task automatic regs_case();
        rd(7'h03, 8'h1A);
        rd(7'h04, 8'h0B);
        wr(7'h02, 8'hFF);
        rd(7'h02, 8'h7B);
        wr(7'h05, 8'hFF);
        rd(7'h05, 8'h00);
        wr(7'h03, 8'h00);
        wr(7'h04, 8'h03);
        rd(7'h04, 8'h03);
    endtask
    task automatic tx_case(logic [1:0] sel, logic [1:0] dm);
        int m;
        m = (dm != DM_PACKET || sel == 2'h3) ? 0 : int'(sel);
        wr(7'h02, {1'b0, dm, 5'h00});
        line_coding_select <= sel;
        q.delete();
        line_partner_inst.cap.delete();
        line_partner_inst.stamp.delete();
        lf = LFSR_SEED;
        crc = CRC_SEED;
        crc_in(8'h3C);
        crc_in(8'h81);
        put(8'hF0, 0);
        put(8'h3C, m);
        put(8'h81, m);
        put(~crc[15:8], m);
        put(~crc[7:0], m);
        send(8'hF0, 1'b1, 1'b0);
        send(8'h3C, 1'b0, 1'b0);
        send(8'h81, 1'b0, 1'b1);
        wait_ready();
        // Let the model capture the last strobe before counting
        @(posedge clk);
        check("chips", 16'(line_partner_inst.cap.size()), 16'(q.size()));
        foreach (q[i]) check("chip", line_partner_inst.cap[i], q[i]);
        check("rate", 16'(line_partner_inst.stamp[9] -
            line_partner_inst.stamp[8]), 16'h0003);
    endtask
    task automatic rx_case(logic [1:0] sel, logic [7:0] b, logic er);
        int i, k, e;
        k = n_got;
        e = n_cerr;
        lf = LFSR_SEED;
        q.delete();
        put(b, sel == 2'h3 ? 0 : int'(sel));
        if (er) q[1] = q[0];
        line_coding_select <= sel;
        @(posedge clk);
        rx_sync_found <= 1'b1;
        @(posedge clk);
        rx_sync_found <= 1'b0;
        line_partner_inst.play(q);
        for (i = 0; i < 20 && n_got == k; i++) @(posedge clk);
        if (n_got == k) hang();
        rx_stop <= 1'b1;
        @(posedge clk);
        rx_stop <= 1'b0;
        check("rx_byte", got, b);
        check("rx_code_err", 16'(n_cerr - e), 16'(er));
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        regs_case();
        tx_case(LC_NONE, DM_PACKET);
        tx_case(LC_MANCHESTER, DM_PACKET);
        tx_case(LC_WHITEN, DM_PACKET);
        tx_case(2'h3, DM_PACKET);
        tx_case(LC_WHITEN, DM_PACKET);
        wr(7'h02, 8'h00);
        rx_case(LC_MANCHESTER, 8'hC3, 1'b0);
        rx_case(LC_MANCHESTER, 8'hC3, 1'b1);
        rx_case(LC_WHITEN, 8'h5A, 1'b0);
        rx_case(LC_NONE, 8'hA5, 1'b0);
        tx_case(LC_MANCHESTER, DM_CONT_SYNC);
        tx_case(LC_WHITEN, DM_CONT_RAW);
        close_out();
    end
endmodule // tb_dc_free_line_coder
bind dc_free_line_coder coder_properties coder_properties_inst (.clk, .rst,
    .ce, .reg_rd, .reg_rvalid, .line_coding_select, .tx_valid, .tx_ready,
    .tx_chip, .tx_chip_stb, .tx_active, .rx_sync_found, .rx_stop,
    .rx_byte_stb, .rx_code_err, .rx_active);
